// file: hw/ext_dma_write_regs.vh
`ifndef EXT_DMA_WRITE_REGS_VH
`define EXT_DMA_WRITE_REGS_VH

// Register port addresses
`define ADDR_W          4
`define A_DATA          4'h0
`define A_ERROR         4'h1
`define A_COUNT         4'h2
`define A_SECTOR        4'h3
`define A_CYL_LO        4'h4
`define A_CYL_HI        4'h5
`define A_DEV_HEAD      4'h6
`define A_CMD_STATUS    4'h7
`define A_DEV_CTRL      4'h8
`define A_IRQ_STATUS    4'h9
`define A_IRQ_MASK      4'ha
`define A_CONFIG        4'hb

// Opcodes
`define OP_WR_DMA_EXT   8'h35
`define OP_WR_DMA_FUA   8'h3d

// Device control and config bits
`define DC_HOB_BIT      7
`define CFG_CACHE_BIT   0

// Error register bits
`define ERR_CRC_BIT     7
`define ERR_IDN_BIT     4
`define ERR_ABT_BIT     2

// Status register bits
`define ST_BSY_BIT      7
`define ST_RDY_BIT      6
`define ST_DSC_BIT      4
`define ST_DRQ_BIT      3
`define ST_ERR_BIT      0

// Interrupt status bits
`define IRQ_W           2
`define IRQ_DONE_BIT    0
`define IRQ_ERR_BIT     1

// Sector geometry
`define WORDS_LAST      8'hff
`define CNT_W           17
`define CNT_FULL        17'h10000
`define CNT_ONE         17'h00001
`define LBA_ONE         48'h000000000001

`endif

// file: hw/sector_buf.v
`timescale 1ns/1ps
// One-sector word store, registered read
module sector_buf (
  // Clock
  input  wire        core_clk,
  // Write side
  input  wire        wr_en,
  input  wire [7:0]  wr_addr,
  input  wire [15:0] wr_data,
  // Read side
  input  wire        rd_en,
  input  wire [7:0]  rd_addr,
  output reg  [15:0] rd_data
);

  reg [15:0] mem [0:255];

  always @(posedge core_clk)
  begin
    if (wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
    if (rd_en)
    begin
      rd_data <= mem[rd_addr];
    end
  end

endmodule

// file: hw/ext_dma_write_cmd.v
// Chosen here: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`include "ext_dma_write_regs.vh"
module ext_dma_write_cmd (
  // Clock and reset
  input  wire                 core_clk,
  input  wire                 rst_n,
  // Register port
  input  wire [`ADDR_W-1:0]   addr,
  input  wire [15:0]          wdata,
  input  wire                 wr_stb,
  input  wire                 rd_stb,
  output reg  [15:0]          rdata,
  // DMA request toward the host channel
  output reg                  dmarq,
  input  wire                 crc_error,
  // Media write path
  output reg  [15:0]          media_data,
  output reg                  media_valid,
  input  wire                 media_ready,
  output reg  [47:0]          media_lba,
  input  wire                 media_done,
  input  wire                 media_err,
  input  wire                 media_idnf,
  // Interrupt
  output reg                  irq
);

  localparam S_IDLE  = 5'b00001;
  localparam S_XFER  = 5'b00010;
  localparam S_MRD   = 5'b00100;
  localparam S_MSEND = 5'b01000;
  localparam S_MWAIT = 5'b10000;

  reg  [4:0]             state;
  reg  [7:0]             tf_cur [0:2];
  reg  [7:0]             tf_prev [0:2];
  reg  [7:0]             cnt_cur;
  reg  [7:0]             cnt_prev;
  reg  [7:0]             dev_head;
  reg  [7:0]             dev_ctrl;
  reg  [7:0]             config_reg;
  reg  [7:0]             error_flags;
  reg                    err_status;
  reg  [`IRQ_W-1:0]      irq_status;
  reg  [`IRQ_W-1:0]      irq_mask;
  reg  [47:0]            lba;
  reg  [`CNT_W-1:0]      sectors_left;
  reg  [7:0]             word_idx;
  reg                    force_media_write;
  reg                    crc_seen;
  reg  [15:0]            next_rdata;
  reg  [`IRQ_W-1:0]      next_irq_status;

  wire [15:0]            buf_rd_data;
  wire                   busy;
  wire                   tf_write;
  wire                   cmd_write;
  wire                   is_write_op;
  wire                   word_take;
  wire                   last_word_sent;
  wire                   posted;
  wire                   sector_end;
  wire                   sector_fail;
  wire                   finish;
  wire                   abort_cmd;
  wire [15:0]            count16;
  wire [`CNT_W-1:0]      count_req;
  wire [47:0]            lba_req;
  wire                   high_byte_select;

  // Picks the byte a task-file read returns under the high-byte select
  function [7:0] tf_pick;
    input       sel;
    input [7:0] cur;
    input [7:0] prev;
    begin
      tf_pick = sel ? prev : cur;
    end
  endfunction

  assign busy        = (state != S_IDLE);
  assign high_byte_select         = dev_ctrl[`DC_HOB_BIT];
  assign tf_write    = wr_stb && !busy;
  assign cmd_write   = tf_write && (addr == `A_CMD_STATUS);
  assign is_write_op = (wdata[7:0] == `OP_WR_DMA_EXT) ||
                       (wdata[7:0] == `OP_WR_DMA_FUA);
  assign abort_cmd   = cmd_write && !is_write_op;

  assign count16   = {cnt_prev, cnt_cur};
  assign count_req = (count16 == 16'h0000) ? `CNT_FULL
                                           : {1'b0, count16};
  assign lba_req   = {tf_prev[2], tf_prev[1], tf_prev[0],
                      tf_cur[2], tf_cur[1], tf_cur[0]};

  // Host words are taken only while the request is up
  assign word_take = (state == S_XFER) && dmarq && wr_stb &&
                     (addr == `A_DATA);

  assign last_word_sent = (state == S_MSEND) && media_valid && media_ready &&
                          (word_idx == `WORDS_LAST);
  // Cached plain writes may post status once handed to media
  assign posted      = config_reg[`CFG_CACHE_BIT] && !force_media_write;
  assign sector_end  = (last_word_sent && posted) ||
                       ((state == S_MWAIT) && media_done);
  assign sector_fail = sector_end && (crc_seen ||
                       ((state == S_MWAIT) && media_err));
  assign finish      = sector_end && (sector_fail || (sectors_left == `CNT_ONE));

  sector_buf u_sector_buf (
    .core_clk (core_clk),
    .wr_en    (word_take),
    .wr_addr  (word_idx),
    .wr_data  (wdata),
    .rd_en    (state == S_MRD),
    .rd_addr  (word_idx),
    .rd_data  (buf_rd_data)
  );

  // Address bytes: shift on host write, failing address on error
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1)
    begin : g_tf
      always @(posedge core_clk)
      begin
        if (!rst_n)
        begin
          tf_cur[gi]  <= 8'h00;
          tf_prev[gi] <= 8'h00;
        end
        else if (sector_fail)
        begin
          tf_cur[gi]  <= lba[gi*8 +: 8];
          tf_prev[gi] <= lba[gi*8+24 +: 8];
        end
        else if (tf_write && (addr == (`A_SECTOR + gi)))
        begin
          tf_prev[gi] <= tf_cur[gi];
          tf_cur[gi]  <= wdata[7:0];
        end
      end
    end
  endgenerate

  // Remaining host-written registers
  always @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      cnt_cur    <= 8'h00;
      cnt_prev   <= 8'h00;
      dev_head   <= 8'h00;
      dev_ctrl   <= 8'h00;
      config_reg <= 8'h00;
      irq_mask   <= {`IRQ_W{1'b0}};
    end
    else
    begin
      if (tf_write && (addr == `A_COUNT))
      begin
        cnt_prev <= cnt_cur;
        cnt_cur  <= wdata[7:0];
      end
      if (tf_write && (addr == `A_DEV_HEAD))
      begin
        dev_head <= wdata[7:0];
      end
      if (wr_stb && (addr == `A_DEV_CTRL))
      begin
        dev_ctrl <= wdata[7:0];
      end
      if (wr_stb && (addr == `A_CONFIG))
      begin
        config_reg <= wdata[7:0];
      end
      if (wr_stb && (addr == `A_IRQ_MASK))
      begin
        irq_mask <= wdata[`IRQ_W-1:0];
      end
    end
  end

  // Command sequencer
  always @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      state             <= S_IDLE;
      dmarq             <= 1'b0;
      word_idx          <= 8'h00;
      lba               <= 48'h0;
      sectors_left      <= {`CNT_W{1'b0}};
      force_media_write <= 1'b0;
      crc_seen          <= 1'b0;
      media_data        <= 16'h0000;
      media_valid       <= 1'b0;
      media_lba         <= 48'h0;
    end
    else
    begin
      if (busy && crc_error)
      begin
        crc_seen <= 1'b1;
      end
      case (state)
        S_IDLE:
        begin
          if (cmd_write && is_write_op)
          begin
            lba               <= lba_req;
            media_lba         <= lba_req;
            sectors_left      <= count_req;
            force_media_write <= (wdata[7:0] == `OP_WR_DMA_FUA);
            crc_seen          <= 1'b0;
            word_idx          <= 8'h00;
            dmarq             <= 1'b1;
            state             <= S_XFER;
          end
        end
        S_XFER:
        begin
          if (word_take)
          begin
            word_idx <= word_idx + 8'h01;
            if (word_idx == `WORDS_LAST)
            begin
              dmarq <= 1'b0;
              state <= S_MRD;
            end
          end
        end
        S_MRD:
        begin
          state <= S_MSEND;
        end
        S_MSEND:
        begin
          if (!media_valid)
          begin
            media_data  <= buf_rd_data;
            media_valid <= 1'b1;
          end
          else if (media_ready)
          begin
            media_valid <= 1'b0;
            word_idx    <= word_idx + 8'h01;
            if (word_idx == `WORDS_LAST)
            begin
              state <= S_MWAIT;
            end
            else
            begin
              state <= S_MRD;
            end
          end
        end
        S_MWAIT:
        begin
          state <= S_MWAIT;
        end
        default:
        begin
          state <= S_IDLE;
          dmarq <= 1'b0;
        end
      endcase
      // Sector boundary: stop, finish or start the next sector
      if (sector_end)
      begin
        if (finish)
        begin
          state <= S_IDLE;
          dmarq <= 1'b0;
        end
        else
        begin
          lba          <= lba + `LBA_ONE;
          media_lba    <= lba + `LBA_ONE;
          sectors_left <= sectors_left - `CNT_ONE;
          word_idx     <= 8'h00;
          dmarq        <= 1'b1;
          state        <= S_XFER;
        end
      end
    end
  end

  // Ending error and status bits
  always @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      error_flags <= 8'h00;
      err_status  <= 1'b0;
    end
    else if (cmd_write)
    begin
      error_flags <= 8'h00;
      err_status  <= abort_cmd;
      error_flags[`ERR_ABT_BIT] <= abort_cmd;
    end
    else if (sector_fail)
    begin
      err_status <= 1'b1;
      error_flags[`ERR_CRC_BIT] <= crc_seen;
      error_flags[`ERR_IDN_BIT] <= (state == S_MWAIT) && media_err && media_idnf;
      error_flags[`ERR_ABT_BIT] <= (state == S_MWAIT) && media_err && !media_idnf;
    end
  end

  // Sticky interrupt events; set wins over a same-cycle clear
  always @*
  begin
    next_irq_status = irq_status;
    if (wr_stb && (addr == `A_IRQ_STATUS))
    begin
      next_irq_status = irq_status & ~wdata[`IRQ_W-1:0];
    end
    if (finish || abort_cmd)
    begin
      next_irq_status[`IRQ_DONE_BIT] = 1'b1;
    end
    if (sector_fail || abort_cmd)
    begin
      next_irq_status[`IRQ_ERR_BIT] = 1'b1;
    end
  end

  always @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      irq_status <= {`IRQ_W{1'b0}};
      irq        <= 1'b0;
    end
    else
    begin
      irq_status <= next_irq_status;
      irq        <= |(next_irq_status & irq_mask);
    end
  end

  // Read mux, data in the cycle after the strobe
  always @*
  begin
    next_rdata = 16'h0000;
    case (addr)
      `A_ERROR:      next_rdata = {8'h00, error_flags};
      `A_COUNT:      next_rdata = {8'h00, tf_pick(high_byte_select, cnt_cur, cnt_prev)};
      `A_SECTOR:     next_rdata = {8'h00, tf_pick(high_byte_select, tf_cur[0], tf_prev[0])};
      `A_CYL_LO:     next_rdata = {8'h00, tf_pick(high_byte_select, tf_cur[1], tf_prev[1])};
      `A_CYL_HI:     next_rdata = {8'h00, tf_pick(high_byte_select, tf_cur[2], tf_prev[2])};
      `A_DEV_HEAD:   next_rdata = {8'h00, dev_head};
      `A_CMD_STATUS:
      begin
        next_rdata[`ST_BSY_BIT] = busy;
        next_rdata[`ST_RDY_BIT] = 1'b1;
        next_rdata[`ST_DSC_BIT] = 1'b1;
        next_rdata[`ST_DRQ_BIT] = dmarq;
        next_rdata[`ST_ERR_BIT] = err_status;
      end
      `A_DEV_CTRL:   next_rdata = {8'h00, dev_ctrl};
      `A_IRQ_STATUS: next_rdata = {{(16-`IRQ_W){1'b0}}, irq_status};
      `A_IRQ_MASK:   next_rdata = {{(16-`IRQ_W){1'b0}}, irq_mask};
      `A_CONFIG:     next_rdata = {8'h00, config_reg};
      default:       next_rdata = 16'h0000;
    endcase
  end

  always @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      rdata <= 16'h0000;
    end
    else if (rd_stb)
    begin
      rdata <= next_rdata;
    end
    else
    begin
      rdata <= 16'h0000;
    end
  end

endmodule

// file: dv/ext_dma_write_checker.sv
`timescale 1ns/1ps
module ext_dma_write_checker (
  // Clock and reset
  input wire        core_clk,
  input wire        rst_n,
  // Register port
  input wire [3:0]  addr,
  input wire        wr_stb,
  input wire        rd_stb,
  input wire [15:0] rdata,
  // DMA and media
  input wire        dmarq,
  input wire [15:0] media_data,
  input wire        media_valid,
  input wire        media_ready,
  input wire [47:0] media_lba,
  input wire        media_done,
  input wire        media_err,
  input wire        irq
);
  reg  [8:0] wcnt;
  wire       word = wr_stb && addr == 4'h0 && dmarq;

  // Words taken in the current sector
  always @(posedge core_clk)
    if (!rst_n || !dmarq)
      wcnt <= 9'h0;
    else if (word)
      wcnt <= wcnt + 9'h1;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence last_word;
    word && wcnt == 9'hff;
  endsequence

  a_dmarq_drop: assert property (last_word |=> !dmarq)
    else $error("dmarq held past sector end");
  a_sector_len: assert property ($fell(dmarq) |-> $past(wcnt) == 9'hff && $past(word))
    else $error("dmarq fell before a full sector");
  a_status_fixed: assert property (rd_stb && addr == 4'h7 |=> rdata[6] && rdata[4] && !rdata[5] && !rdata[2])
    else $error("status fixed bits wrong");
  a_status_drq: assert property (rd_stb && addr == 4'h7 |=> rdata[3] == $past(dmarq))
    else $error("status request bit differs from dmarq");
  a_irq_after_xfer: assert property ($rose(irq) |-> !dmarq && !media_valid)
    else $error("interrupt before transfer end");
  a_media_hold: assert property (media_valid && !media_ready |=> media_valid && $stable(media_data) && $stable(media_lba))
    else $error("media word dropped while stalled");
  a_buffer_first: assert property (media_valid |-> !dmarq)
    else $error("media write during host transfer");
  a_err_stops: assert property (media_done && media_err |=> !dmarq [*8])
    else $error("transfer went on after failure");
  a_rdata_idle: assert property (!rd_stb |=> rdata == 16'h0)
    else $error("read data outside read cycle");
endmodule

// file: dv/media_model.sv
`timescale 1ns/1ps
module media_model (
  // Clock and reset
  input  wire       core_clk,
  input  wire       rst_n,
  // Test control
  input  wire       slow,
  input  wire [7:0] fail_at,
  input  wire       clr,
  // Media side
  input  wire       media_valid,
  output wire       media_ready,
  output reg        media_done,
  output reg        media_err,
  output reg        media_idnf
);
  reg [8:0] words;
  reg [7:0] secs;
  reg [1:0] tick;

  // Takes one word in four when slow
  assign media_ready = !slow || tick == 2'h3;

  always @(posedge core_clk)
  begin
    tick <= rst_n ? tick + 2'h1 : 2'h0;
    media_done <= 1'b0;
    media_err <= 1'b0;
    media_idnf <= 1'b0;
    if (!rst_n || clr)
    begin
      words <= 9'h0;
      secs <= 8'h0;
    end
    else if (words == 9'h100)
    begin
      // One completion per sector, the chosen one fails
      media_done <= 1'b1;
      media_err <= secs == fail_at;
      media_idnf <= secs == fail_at;
      words <= 9'h0;
      secs <= secs + 8'h1;
    end
    else if (media_valid && media_ready)
      words <= words + 9'h1;
  end
endmodule

// file: dv/ext_dma_write_cmd_tb_top.sv
`timescale 1ns/1ps
`include "ext_dma_write_regs.vh"
module ext_dma_write_cmd_tb_top;
  reg         core_clk, rst_n, wr_stb, rd_stb, slow, clr, crc_error;
  reg  [3:0]  addr;
  reg  [15:0] wdata, d;
  reg  [7:0]  fail_at;
  reg  [47:0] fl;
  wire [15:0] rdata, media_data;
  wire [47:0] media_lba;
  wire        dmarq, media_valid, media_ready, media_done, media_err, media_idnf, irq;
  integer     failures, checks, cyc, dones;
  reg  [15:0] q[$];

  ext_dma_write_cmd i_ext_dma_write_cmd (.core_clk, .rst_n, .addr, .wdata, .wr_stb,
    .rd_stb, .rdata, .dmarq, .crc_error, .media_data, .media_valid, .media_ready,
    .media_lba, .media_done, .media_err, .media_idnf, .irq);
  media_model i_media_model (.core_clk, .rst_n, .slow, .fail_at, .clr, .media_valid,
    .media_ready, .media_done, .media_err, .media_idnf);

  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task cmp(input [47:0] got, input [47:0] exp);
  begin
    checks = checks + 1;
    if (got !== exp)
    begin
      failures = failures + 1;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  end
  endtask

  task wr(input [3:0] a, input [15:0] v);
  begin
    @(posedge core_clk);
    addr <= a;
    wdata <= v;
    wr_stb <= 1'b1;
    @(posedge core_clk);
    wr_stb <= 1'b0;
  end
  endtask

  task rd(input [3:0] a);
  begin
    @(posedge core_clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge core_clk);
    rd_stb <= 1'b0;
    #1 d = rdata;
  end
  endtask

  task irq_is(input v);
  begin
    @(posedge core_clk);
    #1 cmp(irq, v);
  end
  endtask

  task complete_run;
  begin
    $display("failures=%0d checks=%0d", failures, checks);
    if (failures == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  end
  endtask

  // Words must reach the media whole and in order; sampled mid-cycle where settled
  always @(negedge core_clk)
  begin
    cyc = cyc + 1;
    if (media_done)
      dones = dones + 1;
    if (media_valid && media_ready && q.size() > 0)
      cmp(media_data, q.pop_front());
    if (cyc == 40000)
    begin
      failures = failures + 1;
      complete_run;
    end
  end

  task run(input [7:0] op, input [15:0] cnt, input [47:0] lba, input integer secs);
    integer s, w;
  begin
    wr(4'h2, cnt[15:8]);
    wr(4'h2, cnt[7:0]);
    wr(4'h3, lba[31:24]);
    wr(4'h3, lba[7:0]);
    wr(4'h4, lba[39:32]);
    wr(4'h4, lba[15:8]);
    wr(4'h5, lba[47:40]);
    wr(4'h5, lba[23:16]);
    wr(4'h6, 16'h0040);
    clr <= 1'b1;
    dones = 0;
    wr(4'h7, op);
    clr <= 1'b0;
    for (s = 0; s < secs; s = s + 1)
    begin
      #1 w = 0;
      while (!dmarq && w < 3000)
      begin
        @(posedge core_clk);
        #1 w = w + 1;
      end
      cmp(dmarq, 1'b1);
      for (w = 0; w < 256; w = w + 1)
      begin
        q.push_back({s[7:0], w[7:0]});
        wr(4'h0, {s[7:0], w[7:0]});
      end
      w = 0;
      while (!media_valid && w < 100)
      begin
        @(posedge core_clk);
        #1 w = w + 1;
      end
      cmp(media_lba, lba + s);
    end
    w = 0;
    while (!irq && w < 5000)
    begin
      @(posedge core_clk);
      #1 w = w + 1;
    end
    cmp(irq, 1'b1);
  end
  endtask

  task forced_two_sectors;
  begin
    slow <= 1'b1;
    wr(4'hb, 16'h0001);
    run(`OP_WR_DMA_FUA, 16'h0002, 48'h123456789abc, 2);
    cmp(dones, 2);
    rd(4'h7);
    cmp(d, 16'h0050);
    rd(4'h9);
    cmp(d, 16'h0001);
    wr(4'h9, 16'h0003);
    irq_is(1'b0);
  end
  endtask

  task zero_count_failure;
  begin
    slow <= 1'b0;
    fail_at <= 8'h01;
    fl = 48'h0a0b0c0d0f00;
    wr(4'hb, 16'h0000);
    run(`OP_WR_DMA_EXT, 16'h0000, 48'h0a0b0c0d0eff, 2);
    cmp(dones, 2);
    rd(4'h7);
    cmp(d, 16'h0051);
    rd(4'h1);
    cmp(d[7:0], 8'h10);
    rd(4'h3);
    cmp(d[7:0], fl[7:0]);
    rd(4'h4);
    cmp(d[7:0], fl[15:8]);
    rd(4'h5);
    cmp(d[7:0], fl[23:16]);
    wr(4'h8, 16'h0080);
    rd(4'h3);
    cmp(d[7:0], fl[31:24]);
    rd(4'h4);
    cmp(d[7:0], fl[39:32]);
    rd(4'h5);
    cmp(d[7:0], fl[47:40]);
    wr(4'h8, 16'h0000);
    rd(4'h9);
    cmp(d, 16'h0003);
    wr(4'h9, 16'h0003);
    fail_at <= 8'hff;
  end
  endtask

  task crc_failure;
  begin
    fork
      run(`OP_WR_DMA_EXT, 16'h0001, 48'h000000030201, 1);
      begin
        @(posedge dmarq);
        @(posedge core_clk);
        crc_error <= 1'b1;
        @(posedge core_clk);
        crc_error <= 1'b0;
      end
    join
    rd(4'h1);
    cmp(d[7:0], 8'h80);
    rd(4'h7);
    cmp(d, 16'h0051);
    rd(4'h9);
    cmp(d, 16'h0003);
    wr(4'h9, 16'h0003);
  end
  endtask

  task reset_state;
  begin
    rd(4'h7);
    cmp(d, 16'h0050);
    cmp(dmarq, 1'b0);
    cmp(irq, 1'b0);
    wr(4'ha, 16'h0003);
  end
  endtask

  task posted_and_mask;
  begin
    wr(4'hb, 16'h0001);
    run(`OP_WR_DMA_EXT, 16'h0001, 48'h000000000100, 1);
    cmp(dones, 0);
    wr(4'ha, 16'h0000);
    irq_is(1'b0);
    wr(4'h9, 16'h0000);
    wr(4'ha, 16'h0003);
    irq_is(1'b1);
    wr(4'h9, 16'h0001);
    irq_is(1'b0);
    wr(4'h7, 16'h0030);
    rd(4'h1);
    cmp(d[7:0], 8'h04);
    rd(4'hc);
    cmp(d, 16'h0000);
  end
  endtask

  initial
  begin
    failures = 0;
    checks = 0;
    cyc = 0;
    dones = 0;
    rst_n = 1'b0;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    addr = 4'h0;
    wdata = 16'h0;
    slow = 1'b0;
    clr = 1'b0;
    crc_error = 1'b0;
    fail_at = 8'hff;
    repeat (12) @(posedge core_clk);
    rst_n <= 1'b1;
    reset_state;
    forced_two_sectors;
    zero_count_failure;
    crc_failure;
    posted_and_mask;
    complete_run;
  end
endmodule

bind ext_dma_write_cmd ext_dma_write_checker i_chk (.core_clk, .rst_n, .addr, .wr_stb,
  .rd_stb, .rdata, .dmarq, .media_data, .media_valid, .media_ready, .media_lba,
  .media_done, .media_err, .irq);
